// *** src/sstc_pkg.sv ***
// Constants, reset values and state codes for the slave serial data output block.
// Assumes a single 200 MHz ref_clk domain; the link pins arrive asynchronous.
package sstc_pkg;

  // ----------------------------------------------------------------
  // Widths and queue depth
  // ----------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W      = 6;
  localparam int BIT_W      = 3;
  localparam int SYNC_W     = 2;

  // ----------------------------------------------------------------
  // Field positions and counts
  // ----------------------------------------------------------------
  localparam int              MSB_POS  = 7;
  localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [BIT_W-1:0] BIT_ZERO = 3'h0;
  localparam logic [BIT_W-1:0] BIT_ONE  = 3'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] BYTE_RST      = 8'h00;
  localparam logic              SDO_RST       = 1'h0;
  localparam logic              OE_RST        = 1'h0;
  localparam logic              UNDERFLOW_RST = 1'h0;
  localparam logic [SYNC_W-1:0] SYNC_RST      = 2'h0;

  // ----------------------------------------------------------------
  // Byte sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SHIFT
  } sstc_state_e;

endpackage

// *** src/sstc_fifo.sv ***
// Transmit queue: a show-ahead FIFO whose head word comes out of a register.
// Assumes one clock for both sides; depth is a power of two.
`timescale 1ns/100ps

module sstc_fifo
  import sstc_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // Filling side
  input  wire logic [WIDTH-1:0]           wr_data,
  input  wire logic                       wr_valid,
  output      logic                       wr_ready,
  // Draining side
  output      logic [WIDTH-1:0]           rd_data,
  output      logic                       rd_valid,
  input  wire logic                       rd_ready,
  // Status
  output      logic [$clog2(DEPTH+1)-1:0] count,
  output      logic                       empty
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic [WIDTH-1:0]            head;
    logic                        empty;
    logic                        full;
  } sstc_fifo_s;

  sstc_fifo_s state_reg;
  sstc_fifo_s state_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The head register reads the next memory image, so a write into an
  // empty queue is visible one cycle later together with the valid flag.
  always_comb
  begin
    logic do_wr;
    logic do_rd;
    state_next = state_reg;
    do_wr      = wr_valid & ~state_reg.full;
    do_rd      = rd_ready & ~state_reg.empty;
    if (do_wr)
    begin
      state_next.mem[state_reg.wp] = wr_data;
      state_next.wp                = state_reg.wp + PW'(1);
    end
    if (do_rd)
    begin
      state_next.rp = state_reg.rp + PW'(1);
    end
    case ({do_wr, do_rd})
      2'b10:   state_next.cnt = state_reg.cnt + CW'(1);
      2'b01:   state_next.cnt = state_reg.cnt - CW'(1);
      default: state_next.cnt = state_reg.cnt;
    endcase
    state_next.empty = (state_next.cnt == CW'(0));
    state_next.full  = (state_next.cnt == CW'(DEPTH));
    state_next.head  = state_next.mem[state_next.rp];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg       <= '0;
      state_reg.empty <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wr_ready = ~state_reg.full;
  assign rd_valid = ~state_reg.empty;
  assign rd_data  = state_reg.head;
  assign count    = state_reg.cnt;
  assign empty    = state_reg.empty;

endmodule

// *** src/sstc_top.sv ***
// Slave serial data output control with its transmit queue.
// Assumes the master drives the clock and select pins; all link pins are
// sampled by ref_clk, which must run well above the link bit rate.
`timescale 1ns/100ps

module sstc_top
  import sstc_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,

  // Link pins from the master
  input  wire logic              sck_pin,
  input  wire logic              ss_pin,
  input  wire logic              sdi_pin,

  // Serial data output pin
  output      logic              sdo_out,
  output      logic              sdo_oe,

  // Pin and mode controls
  input  wire logic              pin_direction_bit,
  input  wire logic              pin_output_latch_bit,
  input  wire logic              transmit_data_required,
  input  wire logic              select_polarity_control,
  input  wire logic              select_force_control,
  input  wire logic              clock_polarity,
  input  wire logic              clock_edge_select,

  // Transmit queue filling side
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              tx_valid,
  output      logic              tx_ready,

  // Status
  output      logic              tx_fifo_empty_flag,
  output      logic [CNT_W-1:0]  tx_fifo_count,
  output      logic              tx_underflow_flag,
  input  wire logic              tx_underflow_clear,
  output      logic              select_active,

  // Received bytes
  output      logic [DATA_W-1:0] rx_data,
  output      logic              rx_valid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_W-1:0] sck_sync;
    logic [SYNC_W-1:0] ss_sync;
    logic [SYNC_W-1:0] sdi_sync;
    logic              sck_prev;
    logic              active;
    sstc_state_e       fsm;
    logic [BIT_W-1:0]  bit_cnt;
    logic [DATA_W-1:0] tx_shift;
    logic [DATA_W-1:0] rx_shift;
    logic [DATA_W-1:0] last_rx;
    logic              rx_valid;
    logic              underflow;
    logic              sdo_out;
    logic              sdo_oe;
  } sstc_top_s;

  sstc_top_s state_reg;
  sstc_top_s state_next;

  logic [DATA_W-1:0] q_head;
  logic              q_valid;
  logic              q_pop;
  logic              q_empty;
  logic [CNT_W-1:0]  q_count;

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  sstc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr_data  (tx_data),
    .wr_valid (tx_valid),
    .wr_ready (tx_ready),
    .rd_data  (q_head),
    .rd_valid (q_valid),
    .rd_ready (q_pop),
    .count    (q_count),
    .empty    (q_empty)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Effective select: the polarity flips the pin, the force overrides it.
  function automatic logic select_true(input logic pin_level,
                                       input logic pol_low,
                                       input logic force_on);
    select_true = force_on | (pin_level ^ pol_low);
  endfunction

  // Source of the next byte: queue head if any, else the last received byte.
  function automatic logic [DATA_W-1:0] pick_byte(input logic              empty_now,
                                                  input logic [DATA_W-1:0] head,
                                                  input logic [DATA_W-1:0] last);
    pick_byte = empty_now ? last : head;
  endfunction

  // The queue is popped only when transmit data is required.
  assign q_pop = (state_reg.fsm == ST_LOAD) & state_reg.active
               & transmit_data_required & ~q_empty;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic sck_eff;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic shift_edge;
    logic sdi_bit;
    logic [DATA_W-1:0] rx_full;

    state_next = state_reg;

    // Link inputs pass two flops before anything looks at them.
    state_next.sck_sync = {state_reg.sck_sync[0], sck_pin};
    state_next.ss_sync  = {state_reg.ss_sync[0], ss_pin};
    state_next.sdi_sync = {state_reg.sdi_sync[0], sdi_pin};

    sck_eff     = state_reg.sck_sync[1] ^ clock_polarity;
    state_next.sck_prev = sck_eff;
    lead_edge   = sck_eff & ~state_reg.sck_prev;
    trail_edge  = ~sck_eff & state_reg.sck_prev;
    sample_edge = clock_edge_select ? lead_edge : trail_edge;
    shift_edge  = clock_edge_select ? trail_edge : lead_edge;
    sdi_bit     = state_reg.sdi_sync[1];
    rx_full     = {state_reg.rx_shift[DATA_W-2:0], sdi_bit};

    state_next.active = select_true(state_reg.ss_sync[1],
                                    select_polarity_control,
                                    select_force_control);
    state_next.rx_valid = 1'b0;

    // Byte sequencer. The clock is ignored while select is false.
    case (state_reg.fsm)
      ST_IDLE:
      begin
        state_next.bit_cnt = BIT_ZERO;
        if (state_reg.active)
        begin
          state_next.fsm = ST_LOAD;
        end
      end

      ST_LOAD:
      begin
        state_next.bit_cnt  = BIT_ZERO;
        state_next.tx_shift = pick_byte(q_empty, q_head, state_reg.last_rx);
        if (q_empty && transmit_data_required)
        begin
          state_next.underflow = 1'b1;
        end
        state_next.fsm = ST_SHIFT;
      end

      ST_SHIFT:
      begin
        if (shift_edge && (state_reg.bit_cnt != BIT_ZERO))
        begin
          state_next.tx_shift = {state_reg.tx_shift[DATA_W-2:0], 1'b0};
        end
        if (sample_edge)
        begin
          state_next.rx_shift = rx_full;
          state_next.bit_cnt  = state_reg.bit_cnt + BIT_ONE;
          if (state_reg.bit_cnt == LAST_BIT)
          begin
            // A full byte: it becomes the fallback data and the next byte
            // is fetched at once, well before the next shifting edge.
            state_next.last_rx  = rx_full;
            state_next.rx_valid = 1'b1;
            state_next.fsm      = ST_LOAD;
          end
        end
      end

      default:
      begin
        state_next.fsm = ST_IDLE;
      end
    endcase

    // Losing select ends the byte at once; a partial byte is dropped.
    if (!state_reg.active)
    begin
      state_next.fsm     = ST_IDLE;
      state_next.bit_cnt = BIT_ZERO;
    end

    // Clearing the underflow flag loses to a new underflow in the same cycle while select is active.
    if (tx_underflow_clear && !(state_reg.fsm == ST_LOAD && q_empty
                                && transmit_data_required && state_reg.active))
    begin
      state_next.underflow = 1'b0;
    end

    // Pin drive follows the next select state so that drive and data move
    // together; sdo_oe changes in the same cycle as select_active, with no extra cycle on the select path.
    if (!pin_direction_bit)
    begin
      state_next.sdo_oe = 1'b1;
      if (state_next.active)
      begin
        state_next.sdo_out = state_next.tx_shift[MSB_POS];
      end
      else
      begin
        state_next.sdo_out = pin_output_latch_bit;
      end
    end
    else
    begin
      state_next.sdo_oe  = transmit_data_required & state_next.active;
      state_next.sdo_out = state_next.tx_shift[MSB_POS];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg           <= '0;
      state_reg.sck_sync  <= SYNC_RST;
      state_reg.ss_sync   <= SYNC_RST;
      state_reg.sdi_sync  <= SYNC_RST;
      state_reg.fsm       <= ST_IDLE;
      state_reg.tx_shift  <= BYTE_RST;
      state_reg.rx_shift  <= BYTE_RST;
      state_reg.last_rx   <= BYTE_RST;
      state_reg.underflow <= UNDERFLOW_RST;
      state_reg.sdo_out   <= SDO_RST;
      state_reg.sdo_oe    <= OE_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdo_out            = state_reg.sdo_out;
  assign sdo_oe             = state_reg.sdo_oe;
  assign tx_underflow_flag  = state_reg.underflow;
  assign select_active      = state_reg.active;
  assign rx_data            = state_reg.last_rx;
  assign rx_valid           = state_reg.rx_valid;
  assign tx_fifo_empty_flag = q_empty;
  assign tx_fifo_count      = q_count;

endmodule

// *** verif/sstc_top_props.sv ***
// Checker of the data output block, seeing only the top ports.
// Assumes one ref_clk domain; bound from the bench top file.
`timescale 1ns/100ps

module sstc_top_props
  import sstc_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             nrst,
  // Pins and controls
  input wire logic             ss_pin,
  input wire logic             sdo_out,
  input wire logic             sdo_oe,
  input wire logic             pin_direction_bit,
  input wire logic             pin_output_latch_bit,
  input wire logic             transmit_data_required,
  input wire logic             select_polarity_control,
  input wire logic             select_force_control,
  // Status
  input wire logic             tx_fifo_empty_flag,
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic             tx_underflow_flag,
  input wire logic             tx_underflow_clear,
  input wire logic             select_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Three cycles of margin cover the register stages behind the pin.
  sequence idle_drive_s;
    (!pin_direction_bit && !select_active && $stable(pin_output_latch_bit)) [*3];
  endsequence
  sequence hi_z_s;
    (pin_direction_bit && !transmit_data_required) [*3];
  endsequence

  empty_at_zero_a: assert property (tx_fifo_empty_flag == (tx_fifo_count == 6'h00))
    else $error("empty flag wrong");
  latch_idle_a: assert property (idle_drive_s |-> sdo_out == pin_output_latch_bit)
    else $error("idle pin not at latch");
  always_driven_a: assert property (!pin_direction_bit [*3] |-> sdo_oe)
    else $error("pin not driven");
  tri_state_a: assert property (hi_z_s |-> !sdo_oe)
    else $error("pin driven while released");
  pop_by_one_a: assert property (
    tx_fifo_count < $past(tx_fifo_count) |->
    tx_fifo_count == $past(tx_fifo_count) - 6'h01 && $past(transmit_data_required))
    else $error("bad queue pop");
  underflow_cause_a: assert property (
    $rose(tx_underflow_flag) |-> $past(transmit_data_required))
    else $error("underflow without request");
  underflow_hold_a: assert property (
    tx_underflow_flag && !tx_underflow_clear |=> tx_underflow_flag)
    else $error("underflow lost");
  forced_select_a: assert property (select_force_control [*6] |-> select_active)
    else $error("forced select inactive");
  low_select_idle_a: assert property (
    (select_polarity_control && !select_force_control && ss_pin) [*6] |-> !select_active)
    else $error("select active at high pin");
endmodule

// *** verif/sstc_master.sv ***
// Behavioural master: one byte per frame, clock idle low, data out on falling edges.
// Assumes the slave shows its first bit from select and shifts on falling edges.
`timescale 1ns/100ps

module sstc_master
(
  // Link pins
  output logic      sck_pin,
  output logic      ss_pin,
  output logic      sdi_pin,
  input  wire logic sdo_line
);
  initial
  begin
    sck_pin = 1'h0;
    ss_pin  = 1'h1;
    sdi_pin = 1'h0;
  end

  // The clock stands low between frames; the data line then shows the inverse
  // of its last bit so that a stale value is never taken for a good one.
  task automatic xfer(input logic [7:0] tx, input logic act_low, output logic [7:0] rx);
    ss_pin = !act_low;
    #100;
    for (int i = 7; i >= 0; i--)
    begin
      sdi_pin = tx[i];
      #32 sck_pin = 1'h1;
      rx[i] = sdo_line;
      #32 sck_pin = 1'h0;
    end
    sdi_pin = !sdi_pin;
    #50 ss_pin = act_low;
    #100;
  endtask
endmodule

// *** verif/tb_sstc_top.sv ***
// Bench: behavioural master on the link, queue model compared at every frame.
// Assumes the design package is compiled first.
`timescale 1ns/100ps

module tb_sstc_top
  import sstc_pkg::*;
;
  logic ref_clk, nrst, sck_pin, ss_pin, sdi_pin, sdo_out, sdo_oe;
  logic pin_direction_bit, pin_output_latch_bit, transmit_data_required;
  logic select_polarity_control, select_force_control, tx_valid, tx_ready;
  logic tx_fifo_empty_flag, tx_underflow_flag, tx_underflow_clear, select_active, uf_exp;
  logic [DATA_W-1:0] tx_data, rx_data, last_rx;
  logic [CNT_W-1:0]  tx_fifo_count;
  logic [7:0]        q[$];
  logic [31:0]       lfsr_reg;
  logic              rx_valid;
  int                error_cnt, n_compared, cyc_cnt, rx_cnt, frm_cnt;
  wire               sdo_line;

  assign sdo_line = sdo_oe ? sdo_out : 1'hz;
  always #2.5 ref_clk = !ref_clk;

  sstc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .sck_pin(sck_pin), .ss_pin(ss_pin),
    .sdi_pin(sdi_pin), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .pin_direction_bit(pin_direction_bit), .pin_output_latch_bit(pin_output_latch_bit),
    .transmit_data_required(transmit_data_required), .clock_polarity(1'h0),
    .select_polarity_control(select_polarity_control), .clock_edge_select(1'h1),
    .select_force_control(select_force_control), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_fifo_empty_flag(tx_fifo_empty_flag), .rx_valid(rx_valid),
    .tx_fifo_count(tx_fifo_count), .tx_underflow_flag(tx_underflow_flag),
    .tx_underflow_clear(tx_underflow_clear), .select_active(select_active),
    .rx_data(rx_data));
  sstc_master mst_u (.sck_pin(sck_pin), .ss_pin(ss_pin), .sdi_pin(sdi_pin),
    .sdo_line(sdo_line));

  function automatic logic [7:0] rnd8();
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg[7:0];
  endfunction

  task automatic compare_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Every byte start takes the queue head or, when empty, the last byte heard.
  function automatic logic [7:0] load_byte();
    logic [7:0] b;
    b = (q.size() != 0) ? q[0] : last_rx;
    if (transmit_data_required && q.size() != 0)
      void'(q.pop_front());
    else if (transmit_data_required)
      uf_exp = 1'h1;
    return b;
  endfunction

  task automatic push(input logic [7:0] b);
    @(negedge ref_clk);
    tx_data = b;
    tx_valid = 1'h1;
    if (tx_ready === 1'h1)
      q.push_back(b);
    @(negedge ref_clk);
    tx_valid = 1'h0;
  endtask

  // Polarity moves only with transmit off, so a select glitch cannot pop.
  task automatic set_mode(input logic dir, input logic req, input logic pol);
    @(negedge ref_clk);
    transmit_data_required = 1'h0;
    select_polarity_control = pol;
    mst_u.ss_pin = pol;
    repeat (10) @(negedge ref_clk);
    pin_direction_bit = dir;
    transmit_data_required = req;
    repeat (4) @(negedge ref_clk);
  endtask

  // The design loads again after the eighth bit, before select drops.
  task automatic frame();
    logic [7:0] tx, rx, exp;
    tx = rnd8();
    exp = load_byte();
    if (pin_direction_bit && !transmit_data_required)
      exp = 8'hzz;
    mst_u.xfer(tx, select_polarity_control, rx);
    void'(load_byte());
    last_rx = tx;
    repeat (8) @(negedge ref_clk);
    compare_val(rx, exp);
    compare_val(rx_data, tx);
    frm_cnt++;
    compare_val(8'(rx_cnt), 8'(frm_cnt));
    compare_val(8'(tx_fifo_count), 8'(q.size()));
    compare_val(8'(tx_underflow_flag), 8'(uf_exp));
    tx_underflow_clear = 1'h1;
    @(negedge ref_clk);
    tx_underflow_clear = 1'h0;
    uf_exp = 1'h0;
  endtask

  // Each full byte heard must give exactly one receive pulse.
  always @(posedge ref_clk)
  begin
    if (rx_valid === 1'h1)
      rx_cnt++;
  end

  always @(posedge ref_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000)
    begin
      error_cnt++;
      final_report();
    end
  end

  initial
  begin
    {ref_clk, nrst, tx_valid, tx_underflow_clear, select_force_control} = 5'h00;
    {pin_direction_bit, pin_output_latch_bit, transmit_data_required} = 3'h0;
    select_polarity_control = 1'h1;
    tx_data = 8'h00;
    last_rx = 8'h00;
    uf_exp = 1'h0;
    lfsr_reg = 32'h3d951994;
    error_cnt = 0;
    n_compared = 0;
    cyc_cnt = 0;
    rx_cnt = 0;
    frm_cnt = 0;
    repeat (20) @(negedge ref_clk);
    nrst = 1'h1;
    compare_val(8'(tx_fifo_empty_flag), 8'h01);
    set_mode(1'h0, 1'h0, 1'h1);
    for (int v = 0; v < 2; v++)
    begin
      pin_output_latch_bit = v[0];
      repeat (4) @(negedge ref_clk);
      compare_val(8'(sdo_oe), 8'h01);
      compare_val(8'(sdo_out), 8'(v));
    end
    frame();
    for (int m = 0; m < 4; m++)
    begin
      set_mode(m[1], m[0], !m[1]);
      push(rnd8());
      push(rnd8());
      repeat (3) frame();
    end
    set_mode(1'h0, 1'h1, 1'h1);
    repeat (FIFO_DEPTH + 1) push(rnd8());
    compare_val(8'(tx_fifo_count), 8'(FIFO_DEPTH));
    compare_val(8'(tx_ready), 8'h00);
    repeat (FIFO_DEPTH / 2) frame();
    compare_val(8'(tx_fifo_empty_flag), 8'h01);
    set_mode(1'h0, 1'h0, 1'h1);
    select_force_control = 1'h1;
    repeat (10) @(negedge ref_clk);
    compare_val(8'(select_active), 8'h01);
    select_force_control = 1'h0;
    repeat (10) @(negedge ref_clk);
    compare_val(8'(select_active), 8'h00);
    final_report();
  end
endmodule

bind sstc_top sstc_top_props chk_u (.ref_clk(ref_clk), .nrst(nrst), .ss_pin(ss_pin),
  .sdo_out(sdo_out), .sdo_oe(sdo_oe), .pin_direction_bit(pin_direction_bit),
  .pin_output_latch_bit(pin_output_latch_bit),
  .transmit_data_required(transmit_data_required),
  .select_polarity_control(select_polarity_control),
  .select_force_control(select_force_control), .tx_fifo_empty_flag(tx_fifo_empty_flag),
  .tx_fifo_count(tx_fifo_count), .tx_underflow_flag(tx_underflow_flag),
  .tx_underflow_clear(tx_underflow_clear), .select_active(select_active));
